// >>> rtl/ppx_crossbar_top.sv
// Purpose: Priority crossbar placing peripheral signals on port pins.
// Assumes: Byte register port clocked by CLK_SYS, one access a cycle.
// Notes: Pin controls follow register contents one clock later.
`timescale 1ns/1ns

// Behaviour
// - Fixed priority order, serial port first
// - Each non-serial function takes lowest free pin
// - Skipped pins treated as already taken
// - Serial transmit P0.4, receive P0.5 always
// - SMBus and serial port claim pairs
// - Leftover pins act as general-purpose I/O
// - SPI slave select only in four-wire
// - Crossbar off: drivers off, pins input
// - Enable bit activates routing and outputs
// - Input mode 1 digital; reset digital
// - Analog pin: pull-up, driver, receiver off
// - Per-pin output mode; SMBus open-drain
// - Pull-up on open-drain unless driving low
// - Digital pin transitions feed event triggers
// - Events on digital pins, never analog
// - Low route bits 7:6 read zero
// - Low route bits 0-5 select functions
module ppx_crossbar_top
    import ppx_pkg::*;
#(
    parameter int NUM_PORTS = 3
)
(
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic [1:0] SPI_NSS_MODE,
    input wire logic [NUM_SLOTS-1:0] PERIPH_OUT,
    input wire logic [NUM_SLOTS-1:0] PERIPH_OE,
    output logic [NUM_SLOTS-1:0] PERIPH_IN,
    input wire logic [NUM_PORTS*PORT_BITS-1:0] GPIO_OUT,
    input wire logic [NUM_PORTS*PORT_BITS-1:0] PIN_IN,
    output logic [NUM_PORTS*PORT_BITS-1:0] PIN_OUT,
    output logic [NUM_PORTS*PORT_BITS-1:0] PIN_OE,
    output logic [NUM_PORTS*PORT_BITS-1:0] PIN_PULLUP,
    output logic [NUM_PORTS*PORT_BITS-1:0] PIN_RX_EN,
    output logic [NUM_PORTS*PORT_BITS-1:0] EVENT_LEVEL,
    output logic [NUM_PORTS*PORT_BITS-1:0] EVENT_EDGE
);
    localparam int NP = NUM_PORTS * PORT_BITS;

    // Fixed serial pins must exist; byte blocks must not overlap
    if (NUM_PORTS < 1 || NUM_PORTS > 4)
    begin : g_bad_ports
        $error("NUM_PORTS must be 1 to 4");
    end

    // Lowest zero bit of a taken mask, one-hot
    function automatic logic [NP-1:0] first_free(
        input logic [NP-1:0] t);
        return ~t & (t + NP'(1));
    endfunction

    // Address match for the byte-per-port registers
    function automatic logic addr_hit(input logic [7:0] addr,
        input logic [7:0] base, input int idx);
        return addr == (base + 8'(idx));
    endfunction

    logic [7:0] route_low_q; // Function selects
    logic [7:0] route_high_q; // Enable, pull-up disable
    logic [NP-1:0] inmode_q; // 1 digital, 0 analog
    logic [NP-1:0] skip_q; // Pins the walk passes over
    logic [NP-1:0] outmode_q; // 1 push-pull, 0 open-drain
    logic xbar_on; // Crossbar enable
    logic wpud; // Weak pull-up disable
    logic four_wire; // SPI uses slave select
    logic [NUM_SLOTS-1:0] want; // Slots asking for a pin
    logic [NP-1:0] grant [NUM_SLOTS]; // One-hot pin per slot
    logic [NP-1:0] taken [NUM_SLOTS+1]; // Pins used so far
    logic [NUM_SLOTS-1:0] pin_slot [NP]; // Slots owning each pin
    logic [NP-1:0] smb_pin; // Pin carries SDA or SCL
    logic [NP-1:0] pin_level; // Inputs with analog forced low
    logic [NUM_SLOTS-1:0] slot_in_d;
    logic [7:0] rd_chain [NUM_PORTS+1];
    logic wr_low;
    logic wr_high;
    logic [NP-1:0] tx_onehot;
    logic [NP-1:0] rx_onehot;

    assign xbar_on = route_high_q[FLD_ENABLE];
    assign wpud = route_high_q[FLD_WPUD];
    assign four_wire = SPI_NSS_MODE != NSS_MODE_3WIRE;
    assign wr_low = SFR_WR && SFR_ADDR == ADDR_ROUTE_LOW;
    assign wr_high = SFR_WR && SFR_ADDR == ADDR_ROUTE_HIGH;
    assign tx_onehot = NP'(1) << UART_TX_PIN;
    assign rx_onehot = NP'(1) << UART_RX_PIN;

    // Route registers; low bits 7:6 and high bit 2 never store
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            route_low_q <= ROUTE_LOW_RST;
            route_high_q <= ROUTE_HIGH_RST;
        end
        else
        begin
            if (wr_low)
            begin
                route_low_q <= SFR_WDATA & ROUTE_LOW_MASK;
            end
            if (wr_high)
            begin
                route_high_q <= SFR_WDATA & ROUTE_HIGH_MASK;
            end
        end
    end

    // Per-port mode and skip bytes, with read-back chain
    assign rd_chain[0] =
        ((SFR_ADDR == ADDR_ROUTE_LOW) ? route_low_q : 8'h00)
        | ((SFR_ADDR == ADDR_ROUTE_HIGH) ? route_high_q : 8'h00);
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_port
        logic hit_in;
        logic hit_skip;
        logic hit_out;
        assign hit_in = addr_hit(SFR_ADDR, ADDR_INMODE_BASE, i);
        assign hit_skip = addr_hit(SFR_ADDR, ADDR_SKIP_BASE, i);
        assign hit_out = addr_hit(SFR_ADDR, ADDR_OUTMODE_BASE, i);
        assign rd_chain[i+1] = rd_chain[i]
            | (hit_in ? inmode_q[8*i +: 8] : 8'h00)
            | (hit_skip ? skip_q[8*i +: 8] : 8'h00)
            | (hit_out ? outmode_q[8*i +: 8] : 8'h00);

        // Byte write; all pins come up digital
        always_ff @(posedge CLK_SYS)
        begin
            if (!RESET_N)
            begin
                inmode_q[8*i +: 8] <= INMODE_RST;
                skip_q[8*i +: 8] <= SKIP_RST;
                outmode_q[8*i +: 8] <= OUTMODE_RST;
            end
            else if (SFR_WR)
            begin
                if (hit_in)
                begin
                    inmode_q[8*i +: 8] <= SFR_WDATA;
                end
                if (hit_skip)
                begin
                    skip_q[8*i +: 8] <= SFR_WDATA;
                end
                if (hit_out)
                begin
                    outmode_q[8*i +: 8] <= SFR_WDATA;
                end
            end
        end
    end

    // Slot requests; pairs share one select bit
    assign want = {
        route_low_q[FLD_CMP_ASYNC],
        route_low_q[FLD_CMP_SYNC],
        route_low_q[FLD_SYSCLK],
        route_low_q[FLD_SMB],
        route_low_q[FLD_SMB],
        route_low_q[FLD_SPI] & four_wire,
        route_low_q[FLD_SPI],
        route_low_q[FLD_SPI],
        route_low_q[FLD_SPI],
        route_low_q[FLD_UART],
        route_low_q[FLD_UART]
    };

    // Priority walk; skipped pins start out taken
    assign taken[0] = skip_q;
    for (genvar s = 0; s < NUM_SLOTS; s++)
    begin : g_slot
        if (s == SLOT_TX)
        begin : g_tx
            // Serial pins are fixed, skip bits or not
            assign grant[s] = want[s] ? tx_onehot : '0;
        end
        else if (s == SLOT_RX)
        begin : g_rx
            assign grant[s] = want[s] ? rx_onehot : '0;
        end
        else
        begin : g_walk
            // Lowest free pin, then mark it used
            assign grant[s] = want[s] ? first_free(taken[s]) : '0;
        end
        assign taken[s+1] = taken[s] | grant[s];
        // Input seen by the peripheral; idle high when unplaced
        assign slot_in_d[s] = (xbar_on && |grant[s])
            ? |(grant[s] & pin_level) : 1'b1;
    end

    assign pin_level = PIN_IN & inmode_q;

    // Pin view of the grants and one pad cell each
    for (genvar p = 0; p < NP; p++)
    begin : g_pin
        for (genvar s = 0; s < NUM_SLOTS; s++)
        begin : g_tr
            assign pin_slot[p][s] = grant[s][p];
        end
        assign smb_pin[p] = pin_slot[p][SLOT_SDA] | pin_slot[p][SLOT_SCL];

        ppx_pad_cell u_pad (
            .clk(CLK_SYS),
            .reset_n(RESET_N),
            .xbar_en(xbar_on),
            .digital(inmode_q[p]),
            .push_pull(outmode_q[p]),
            .smbus_pin(smb_pin[p]),
            .routed(|pin_slot[p]),
            .periph_val(|(pin_slot[p] & PERIPH_OUT)),
            .periph_drv(|(pin_slot[p] & PERIPH_OE)),
            .gpio_val(GPIO_OUT[p]),
            .pullup_off(wpud),
            .pad_in(PIN_IN[p]),
            .pad_out_q(PIN_OUT[p]),
            .pad_oe_q(PIN_OE[p]),
            .pullup_q(PIN_PULLUP[p]),
            .rx_en_q(PIN_RX_EN[p]),
            .level_q(EVENT_LEVEL[p]),
            .edge_q(EVENT_EDGE[p])
        );

        // No pin serves two signals at once
        a_single_owner: assert property (@(posedge CLK_SYS)
            disable iff (!RESET_N) $countones(pin_slot[p]) <= 1)
            else $error("pin granted to two slots");
        // Analog pin is silent on every path
        a_analog_quiet: assert property (@(posedge CLK_SYS)
            disable iff (!RESET_N) !inmode_q[p] |=> !PIN_OE[p]
            && !PIN_PULLUP[p] && !PIN_RX_EN[p] && !EVENT_EDGE[p])
            else $error("analog pin still active");
        // SMBus line never drives high
        a_smbus_od: assert property (@(posedge CLK_SYS)
            disable iff (!RESET_N) smb_pin[p]
            |=> !(PIN_OE[p] && PIN_OUT[p]))
            else $error("SMBus pin driven high");
    end

    // Registered outputs toward bus and peripherals
    always_ff @(posedge CLK_SYS)
    begin
        if (!RESET_N)
        begin
            SFR_RDATA <= 8'h00;
            PERIPH_IN <= '1;
        end
        else
        begin
            if (SFR_RD)
            begin
                SFR_RDATA <= rd_chain[NUM_PORTS];
            end
            PERIPH_IN <= slot_in_d;
        end
    end

    // Crossbar off leaves every driver off
    a_off_no_drive: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N) !xbar_on |=> PIN_OE == '0)
        else $error("driver on while crossbar disabled");
    // Serial transmit reaches its fixed pin
    a_uart_fixed: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N) (xbar_on && want[SLOT_TX]
        && inmode_q[UART_TX_PIN] && outmode_q[UART_TX_PIN]
        && PERIPH_OE[SLOT_TX]) |=> PIN_OE[UART_TX_PIN]
        && PIN_OUT[UART_TX_PIN] == $past(PERIPH_OUT[SLOT_TX]))
        else $error("serial transmit not on fixed pin");
    // Walk never lands on a skipped pin
    a_skip_honoured: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        ((taken[NUM_SLOTS] & ~taken[SLOT_SCK]) & skip_q) == '0)
        else $error("skipped pin assigned");
    // Three-wire SPI leaves slave select unplaced
    a_spi_three: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N) (SPI_NSS_MODE == NSS_MODE_3WIRE)
        |-> grant[SLOT_NSS] == '0)
        else $error("slave select placed in three-wire mode");
    // Global pull-up disable clears all pull-ups
    a_wpud_off: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N) wpud |=> PIN_PULLUP == '0)
        else $error("pull-up on while disabled");
    // Reserved low route bits 7:6 read back zero
    a_rsvd_zero: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (SFR_RD && SFR_ADDR == ADDR_ROUTE_LOW)
        |=> SFR_RDATA[7:6] == 2'b00)
        else $error("reserved route bits not zero");
    // Clearing the enable silences pins two clocks on
    a_write_effect: assert property (@(posedge CLK_SYS)
        disable iff (!RESET_N)
        (wr_high && !SFR_WDATA[FLD_ENABLE]) |=> ##1 PIN_OE == '0)
        else $error("enable clear did not take effect");
endmodule

// >>> rtl/ppx_pad_cell.sv
// Purpose: Registered drive, pull-up and receive control of one pin.
// Assumes: Pad inputs synchronous to the system clock.
// Notes: Open-drain drives only low; a high releases the pad to its pull-up unless pull-ups are disabled.
`timescale 1ns/1ns
module ppx_pad_cell
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic xbar_en,
    input wire logic digital,
    input wire logic push_pull,
    input wire logic smbus_pin,
    input wire logic routed,
    input wire logic periph_val,
    input wire logic periph_drv,
    input wire logic gpio_val,
    input wire logic pullup_off,
    input wire logic pad_in,
    output logic pad_out_q,
    output logic pad_oe_q,
    output logic pullup_q,
    output logic rx_en_q,
    output logic level_q,
    output logic edge_q
);
    logic val; // Value the pin should show
    logic drv; // Source wants to drive
    logic pp_eff; // Push-pull after SMBus override
    logic oe_d;
    logic pull_d;
    logic lvl_d;
    logic edge_d;

    // Unrouted pins fall back to the port latch
    assign val = routed ? periph_val : gpio_val;
    assign drv = routed ? periph_drv : 1'b1;
    // SMBus lines never drive high
    assign pp_eff = push_pull & ~smbus_pin;
    // Driver only with crossbar on and digital mode
    assign oe_d = xbar_en & digital & drv & (pp_eff | ~val);
    // Pull-up saves power while pulling low
    assign pull_d = digital & ~pullup_off & ~pp_eff
        & ~(oe_d & ~val);
    // Analog pins read zero
    assign lvl_d = digital & pad_in;
    // Edges only between two digital samples
    assign edge_d = digital & rx_en_q & (lvl_d ^ level_q);

    // Pad control flops; reset leaves input with pull-up
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pad_out_q <= 1'b0;
            pad_oe_q <= 1'b0;
            pullup_q <= 1'b1;
            rx_en_q <= 1'b1;
            level_q <= 1'b0;
            edge_q <= 1'b0;
        end
        else
        begin
            pad_out_q <= oe_d & val;
            pad_oe_q <= oe_d;
            pullup_q <= pull_d;
            rx_en_q <= digital;
            level_q <= lvl_d;
            edge_q <= edge_d;
        end
    end
endmodule

// >>> rtl/ppx_pkg.sv
// Purpose: Shared constants for the priority pin crossbar.
// Assumes: Eight pins per port, byte-wide register port.
// Notes: Slot numbers give the fixed placement order.
package ppx_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_ROUTE_LOW = 8'hE1;
    localparam logic [7:0] ADDR_ROUTE_HIGH = 8'hE2;
    localparam logic [7:0] ADDR_INMODE_BASE = 8'hB0;
    localparam logic [7:0] ADDR_SKIP_BASE = 8'hB4;
    localparam logic [7:0] ADDR_OUTMODE_BASE = 8'hB8;
    // Reset values
    localparam logic [7:0] ROUTE_LOW_RST = 8'h00;
    localparam logic [7:0] ROUTE_HIGH_RST = 8'h00;
    localparam logic [7:0] INMODE_RST = 8'hFF;
    localparam logic [7:0] SKIP_RST = 8'h00;
    localparam logic [7:0] OUTMODE_RST = 8'h00;
    // Writable bits; the rest read as zero
    localparam logic [7:0] ROUTE_LOW_MASK = 8'h3F;
    localparam logic [7:0] ROUTE_HIGH_MASK = 8'hFB;
    // Low route register fields
    localparam int FLD_UART = 0;
    localparam int FLD_SPI = 1;
    localparam int FLD_SMB = 2;
    localparam int FLD_SYSCLK = 3;
    localparam int FLD_CMP_SYNC = 4;
    localparam int FLD_CMP_ASYNC = 5;
    // High route register fields
    localparam int FLD_ENABLE = 6;
    localparam int FLD_WPUD = 7;
    // Slave-select mode meaning three-wire
    localparam logic [1:0] NSS_MODE_3WIRE = 2'b00;
    // Fixed serial port pins
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;
    // Signal slots in priority order
    localparam int SLOT_TX = 0;
    localparam int SLOT_RX = 1;
    localparam int SLOT_SCK = 2;
    localparam int SLOT_MISO = 3;
    localparam int SLOT_MOSI = 4;
    localparam int SLOT_NSS = 5;
    localparam int SLOT_SDA = 6;
    localparam int SLOT_SCL = 7;
    localparam int SLOT_SYSCLK = 8;
    localparam int SLOT_CMPS = 9;
    localparam int SLOT_CMPA = 10;
    localparam int NUM_SLOTS = 11;
    localparam int PORT_BITS = 8;
endpackage

// >>> tb/ppx_crossbar_top_bench.sv
// Purpose: Self-checking bench for the priority pin crossbar.
// Assumes: Three ports, inputs driven on the falling clock edge.
// Notes: Expectations queue up; a monitor compares them when due.
`timescale 1ns/1ns
module ppx_crossbar_top_bench;
    import ppx_pkg::*;
    // One pending comparison
    typedef struct {int due; int sel; logic [23:0] exp;} ppx_note_type;
    logic clk_sys = 1'b0;
    logic reset_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rlo, rhi;
    logic [1:0] spi_slave_select_line;
    logic [10:0] pout, poe, per_in, e_per;
    logic [23:0] gpio, ext, pin_in, pin_out, pin_oe, pin_pu, pin_rx;
    logic [23:0] ev_lvl, ev_edge, inm, skp, outm;
    logic [23:0] e_oe, e_out, e_pu, e_pad, e_lvl, e_old;
    int seed, cyc, err_total, compares, i, k;
    ppx_note_type notes[$];
    ppx_note_type n;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    ppx_crossbar_top #(.NUM_PORTS(3)) ppx_crossbar_top_i (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .SFR_ADDR(sfr_addr),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata),
        .SFR_RDATA(sfr_rdata), .SPI_NSS_MODE(spi_slave_select_line), .PERIPH_OUT(pout),
        .PERIPH_OE(poe), .PERIPH_IN(per_in), .GPIO_OUT(gpio),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_PULLUP(pin_pu), .PIN_RX_EN(pin_rx), .EVENT_LEVEL(ev_lvl),
        .EVENT_EDGE(ev_edge));

    ppx_pad_model #(.NP(24)) ppx_pad_model_i (
        .pin_oe(pin_oe), .pin_out(pin_out), .ext_level(ext),
        .pin_in(pin_in));

    // Single comparison point
    task automatic check(string nm, logic [23:0] seen, logic [23:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic push(int sel, logic [23:0] exp, int dly);
        notes.push_back('{cyc + dly, sel, exp});
    endtask

    // Register write: one strobe cycle, a quiet cycle after
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask

    // Register read: data is due one edge after the strobe
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        push(0, {16'h0000, e}, 1);
        @(negedge clk_sys);
        sfr_rd = 1'b0;
    endtask

    // Reference placement and pad behaviour from the bench's own state
    task automatic predict();
        int own [24];
        logic [23:0] tk;
        int p;
        int s;
        logic req, val, pp, want;
        tk = skp;
        e_per = 11'h7FF;
        for (p = 0; p < 24; p++)
            own[p] = -1;
        // Serial pair is pinned regardless of skips
        if (rlo[0])
        begin
            own[4] = SLOT_TX;
            own[5] = SLOT_RX;
            tk[5:4] = 2'b11;
        end
        // Remaining slots take the lowest free pin in priority order
        for (s = 2; s < 11; s++)
        begin
            want = s < 5 ? rlo[1] : s == 5 ? rlo[1] && spi_slave_select_line != 2'b00 :
                s < 8 ? rlo[2] : rlo[s - 5];
            p = 0;
            while (p < 24 && tk[p])
                p++;
            if (want && p < 24)
            begin
                own[p] = s;
                tk[p] = 1'b1;
            end
        end
        for (p = 0; p < 24; p++)
        begin
            req = own[p] < 0 ? 1'b1 : poe[own[p]];
            val = own[p] < 0 ? gpio[p] : pout[own[p]];
            pp = outm[p] && own[p] != SLOT_SDA && own[p] != SLOT_SCL;
            e_oe[p] = rhi[6] && inm[p] && req && (pp || !val);
            e_out[p] = e_oe[p] && val;
            e_pu[p] = inm[p] && !rhi[7] && !pp && !(e_oe[p] && !val);
            e_pad[p] = e_oe[p] ? val : ext[p];
            e_lvl[p] = inm[p] && e_pad[p];
            if (rhi[6] && own[p] >= 0)
                e_per[own[p]] = e_lvl[p];
        end
    endtask

    // Settled pin state, compared four edges on
    task automatic expect_steady();
        push(1, e_oe, 4);
        push(2, e_out, 4);
        push(3, e_pu, 4);
        push(4, inm, 4);
        push(5, e_lvl, 4);
        push(6, 24'h00_0000, 4);
        push(7, {13'h0000, e_per}, 4);
        repeat (4) @(negedge clk_sys);
    endtask

    // Monitor: retire every note whose cycle has come
    always @(negedge clk_sys)
        while (notes.size() > 0 && notes[0].due <= cyc)
        begin
            n = notes.pop_front();
            case (n.sel)
                0: check("rdata", {16'h0000, sfr_rdata}, n.exp);
                1: check("pin_oe", pin_oe, n.exp);
                2: check("pin_out", pin_out, n.exp);
                3: check("pullup", pin_pu, n.exp);
                4: check("rx_en", pin_rx, n.exp);
                5: check("ev_level", ev_lvl, n.exp);
                6: check("ev_edge", ev_edge, n.exp);
                default: check("periph_in", {13'h0000, per_in}, n.exp);
            endcase
        end

    task automatic close_out();
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial
    begin
        #2000000;
        err_total++;
        close_out();
    end

    initial
    begin
        seed = 32'h0000_7baa;
        {cyc, err_total, compares} = '0;
        {reset_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, spi_slave_select_line} = '0;
        {pout, poe, gpio, ext} = '0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset_n = 1'b1;
        // Reset contents, then an unmapped hole
        rd(ADDR_ROUTE_LOW, 8'h00);
        rd(ADDR_ROUTE_HIGH, 8'h00);
        for (k = 0; k < 3; k++)
        begin
            rd(ADDR_INMODE_BASE + 8'(k), 8'hFF);
            rd(ADDR_SKIP_BASE + 8'(k), 8'h00);
            rd(ADDR_OUTMODE_BASE + 8'(k), 8'h00);
        end
        rd(8'h10, 8'h00);
        {rlo, rhi, skp, outm} = '0;
        inm = '1;
        predict();
        expect_steady();
        for (i = 0; i < 50; i++)
        begin
            inm = $random(seed) | $random(seed);
            outm = $random(seed);
            skp = $random(seed) & $random(seed);
            rlo = $random(seed);
            rhi = $random(seed);
            if (i % 4 != 0)
                rhi[6] = 1'b1;
            // Modes, skips, routing, enable last
            for (k = 0; k < 3; k++)
                wr(ADDR_INMODE_BASE + 8'(k), inm[8*k +: 8]);
            for (k = 0; k < 3; k++)
                wr(ADDR_OUTMODE_BASE + 8'(k), outm[8*k +: 8]);
            for (k = 0; k < 3; k++)
                wr(ADDR_SKIP_BASE + 8'(k), skp[8*k +: 8]);
            wr(ADDR_ROUTE_LOW, rlo);
            wr(ADDR_ROUTE_HIGH, rhi);
            rd(ADDR_ROUTE_LOW, rlo & 8'h3F);
            rd(ADDR_ROUTE_HIGH, rhi & 8'hFB);
            pout = $random(seed);
            poe = $random(seed) | $random(seed);
            gpio = $random(seed);
            ext = $random(seed);
            spi_slave_select_line = $random(seed);
            predict();
            expect_steady();
            // Board levels move; digital pins must report the change
            e_old = e_lvl;
            ext = $random(seed);
            predict();
            push(5, e_lvl, 1);
            push(6, e_lvl ^ e_old, 1);
            @(negedge clk_sys);
            push(6, 24'h00_0000, 1);
            @(negedge clk_sys);
        end
        close_out();
    end
endmodule

// >>> tb/ppx_pad_model.sv
// Purpose: Pads and the board beyond them for the pin crossbar bench.
// Assumes: Every pad also has an external source that the bench sets.
// Notes: A driven pad shows the crossbar's value, else the board level.
`timescale 1ns/1ns
module ppx_pad_model
#(
    parameter int NP = 24
)
(
    input wire logic [NP-1:0] pin_oe,
    input wire logic [NP-1:0] pin_out,
    input wire logic [NP-1:0] ext_level,
    output logic [NP-1:0] pin_in
);
    // Board sources are strong, so a weak pull-up never decides a level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
